// ### rtl/isl_if.sv
// Open-drain I2C wires between the bus master end and the slave end.
// Assumes pull-ups: a line is high unless some party enables its low drive.
`timescale 1ns/100ps
`default_nettype none

interface isl_if;
   logic scl_m_oe;
   logic sda_m_oe;
   logic scl_s_oe;
   logic sda_s_oe;
   logic scl;
   logic sda;

   // ==========================================
   // Wired-AND of both parties with a pull-up.
   assign scl = ~(scl_m_oe | scl_s_oe);
   assign sda = ~(sda_m_oe | sda_s_oe);

   modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
   modport slave (output scl_s_oe, output sda_s_oe, input scl, input sda);
endinterface : isl_if

`default_nettype wire

// ### rtl/isl_master.sv
// Bus master end of the I2C link: makes SCL by a divider and runs start, byte and stop commands.
// Assumes a slave that may stretch SCL; the master waits for SCL high before timing a high phase.
`timescale 1ns/100ps
`default_nettype none
`include "isl_params.svh"

module isl_master #(
   parameter int HALF = `ISL_HALF_CYC
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Command port.
   input wire logic cmd_valid_i,
   input wire isl_pkg::isl_cmd_t cmd_i,
   input wire logic [6:0] addr_i,
   input wire logic rw_i,
   input wire logic [7:0] wdata_i,
   input wire logic ack_i,
   output logic cmd_ready_o,
   // Results.
   output logic [7:0] rdata_o,
   output logic nack_o,
   output logic done_o,
   // I2C link.
   isl_if.master bus
);
   import isl_pkg::*;

   isl_mst_reg_t r;
   isl_mst_reg_t next_r;
   logic scl_s;
   logic sda_s;
   logic tick;
   logic [8:0] rx_new;

   isl_sync u_scl (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(bus.scl),
      .deb_i(2'b00),
      .q_o(scl_s)
   );

   isl_sync u_sda (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(bus.sda),
      .deb_i(2'b00),
      .q_o(sda_s)
   );

   // ==========================================
   // Sequencer; SDA changes in the middle of a low phase, except the start in M_S1 and the stop in M_P2, which move it while SCL is high.
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.cnt = r.cnt + 8'h01;
      tick = r.cnt == 8'(HALF - 1);
      rx_new = {r.rx[7:0], sda_s};
      case (r.st)
         M_IDLE: begin
            next_r.cnt = 8'h00;
            next_r.nbit = 4'h0;
            if (cmd_valid_i) begin
               case (cmd_i)
                  CMD_START: begin
                     next_r.tx = {addr_i, rw_i, 1'b1};
                     next_r.st = r.mid ? M_R0 : M_S0;
                  end
                  CMD_WRITE: begin
                     next_r.tx = {wdata_i, 1'b1};
                     next_r.st = M_LOW;
                  end
                  CMD_READ: begin
                     next_r.tx = {8'hff, ack_i};
                     next_r.st = M_LOW;
                  end
                  default: begin
                     next_r.st = M_P0;
                  end
               endcase
            end
         end
         M_R0: begin
            next_r.scl_oe = 1'b1;
            if (r.cnt == 8'(HALF / 2)) begin
               next_r.sda_oe = 1'b0;
            end
            if (tick) begin
               next_r.cnt = 8'h00;
               next_r.st = M_S0;
            end
         end
         M_S0: begin
            next_r.scl_oe = 1'b0;
            next_r.sda_oe = 1'b0;
            if (!scl_s) begin
               next_r.cnt = 8'h00;
            end else if (tick) begin
               next_r.cnt = 8'h00;
               next_r.st = M_S1;
            end
         end
         M_S1: begin
            next_r.sda_oe = 1'b1;
            if (tick) begin
               next_r.cnt = 8'h00;
               next_r.st = M_LOW;
            end
         end
         M_LOW: begin
            next_r.scl_oe = 1'b1;
            if (r.cnt == 8'(HALF / 2)) begin
               next_r.sda_oe = ~r.tx[8];
            end
            if (tick) begin
               next_r.cnt = 8'h00;
               next_r.st = M_HIGH;
            end
         end
         M_HIGH: begin
            next_r.scl_oe = 1'b0;
            if (!scl_s) begin
               next_r.cnt = 8'h00;
            end else if (tick) begin
               next_r.cnt = 8'h00;
               next_r.rx = rx_new;
               next_r.tx = {r.tx[7:0], 1'b1};
               next_r.nbit = r.nbit + 4'h1;
               next_r.st = M_LOW;
               if (r.nbit == `ISL_BYTE_BITS) begin
                  next_r.st = M_IDLE;
                  next_r.done = 1'b1;
                  next_r.mid = 1'b1;
                  next_r.rdata = rx_new[8:1];
                  next_r.nack = rx_new[0];
               end
            end
         end
         M_P0: begin
            next_r.scl_oe = 1'b1;
            if (r.cnt == 8'(HALF / 2)) begin
               next_r.sda_oe = 1'b1;
            end
            if (tick) begin
               next_r.cnt = 8'h00;
               next_r.st = M_P1;
            end
         end
         M_P1: begin
            next_r.scl_oe = 1'b0;
            if (!scl_s) begin
               next_r.cnt = 8'h00;
            end else if (tick) begin
               next_r.cnt = 8'h00;
               next_r.st = M_P2;
            end
         end
         M_P2: begin
            next_r.sda_oe = 1'b0;
            if (tick) begin
               next_r.st = M_IDLE;
               next_r.mid = 1'b0;
               next_r.done = 1'b1;
            end
         end
         default: begin
            next_r.st = M_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign cmd_ready_o = r.st == M_IDLE;
   assign rdata_o = r.rdata;
   assign nack_o = r.nack;
   assign done_o = r.done;
   assign bus.scl_m_oe = r.scl_oe;
   assign bus.sda_m_oe = r.sda_oe;
endmodule : isl_master

`default_nettype wire

// ### rtl/isl_params.svh
// Constants shared by both ends of the I2C slave link: offsets, field positions, reset values and timing.
// Assumes inclusion by bare name from files that also import isl_pkg.
`ifndef ISL_PARAMS_SVH
`define ISL_PARAMS_SVH

// ==========================================
// Register offsets (byte addresses).
`define ISL_OFS_STATUS 4'h0
`define ISL_OFS_DATA 4'h4
`define ISL_OFS_ADDR 4'h8
`define ISL_OFS_CTRL 4'hc

// ==========================================
// Status and control field positions.
`define ISL_B_DONE 7
`define ISL_B_MATCH 6
`define ISL_B_BUSY 5
`define ISL_B_TXD 4
`define ISL_B_ACK_TO_SEND 3
`define ISL_B_RREQ 2
`define ISL_B_WAKE 1
`define ISL_B_ACK_RECEIVED_FLAG 0
`define ISL_STATUS_RST 8'h81
`define ISL_C_EN 0
`define ISL_C_DEB_HI 2
`define ISL_C_DEB_LO 1
`define ISL_ADDR_HI 7
`define ISL_ADDR_LO 1
`define ISL_MSB 7

// ==========================================
// Counts and timing.
`define ISL_BYTE_BITS 4'd8
`define ISL_DEB_NONE 3'd0
`define ISL_DEB_TWO 3'd2
`define ISL_DEB_FOUR 3'd4
`define ISL_CLK_NS 20
`define ISL_HALF_NS 160
`define ISL_HALF_CYC (`ISL_HALF_NS / `ISL_CLK_NS)

`endif

// ### rtl/isl_pkg.sv
// Types of the I2C slave link: state codes, master commands and the state records of each module.
// Assumes nothing of its surroundings.
package isl_pkg;

   // ==========================================
   // Enumerations.
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_ADDR = 3'b001,
      D_AACK = 3'b010,
      D_HOLD = 3'b011,
      D_SETUP = 3'b100,
      D_DATA = 3'b101,
      D_DACK = 3'b110
   } isl_dev_state_t;

   typedef enum logic [3:0] {
      M_IDLE = 4'b0000,
      M_R0 = 4'b0001,
      M_S0 = 4'b0010,
      M_S1 = 4'b0011,
      M_LOW = 4'b0100,
      M_HIGH = 4'b0101,
      M_P0 = 4'b0110,
      M_P1 = 4'b0111,
      M_P2 = 4'b1000
   } isl_mst_state_t;

   typedef enum logic [1:0] {
      CMD_START = 2'b00,
      CMD_WRITE = 2'b01,
      CMD_READ = 2'b10,
      CMD_STOP = 2'b11
   } isl_cmd_t;

   // ==========================================
   // State records.
   typedef struct packed {
      logic ff1;
      logic ff2;
      logic q;
      logic [2:0] cnt;
   } isl_sync_reg_t;

   typedef struct packed {
      isl_dev_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh_addr;
      logic [7:0] data;
      logic [7:0] own;
      logic [7:0] stat;
      logic en;
      logic [1:0] deb;
      logic scl_q;
      logic sda_q;
      logic scl_oe;
      logic sda_oe;
      logic irq;
      logic ack;
      logic [7:0] rd;
   } isl_dev_reg_t;

   typedef struct packed {
      isl_mst_state_t st;
      logic [7:0] cnt;
      logic [3:0] nbit;
      logic [8:0] tx;
      logic [8:0] rx;
      logic scl_oe;
      logic sda_oe;
      logic mid;
      logic [7:0] rdata;
      logic nack;
      logic done;
   } isl_mst_reg_t;

endpackage : isl_pkg

// ### rtl/isl_slave.sv
// Slave end of the I2C link with its firmware registers on a classic Wishbone slave port.
// Assumes an external bus master on the interface and pull-ups on both lines.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "isl_params.svh"

module isl_slave (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Event request.
   output logic irq_o,
   // I2C link.
   isl_if.slave bus
);
   import isl_pkg::*;

   isl_dev_reg_t r;
   isl_dev_reg_t next_r;
   logic scl_s;
   logic sda_s;
   logic req;
   logic wr;
   logic service;
   logic tx;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // ==========================================
   // Line synchronisers; only SCL carries the glitch filter.
   isl_sync u_scl (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(bus.scl),
      .deb_i(r.deb),
      .q_o(scl_s)
   );

   isl_sync u_sda (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(bus.sda),
      .deb_i(2'b00),
      .q_o(sda_s)
   );

   // ==========================================
   // Register access and link engine.
   always_comb begin
      next_r = r;
      next_r.irq = 1'b0;
      next_r.ack = 1'b0;
      next_r.scl_q = scl_s;
      next_r.sda_q = sda_s;
      req = cyc_i & stb_i & ~r.ack;
      wr = req & we_i & sel_i[0];
      tx = r.stat[`ISL_B_TXD];
      service = 1'b0;
      scl_rise = scl_s & ~r.scl_q;
      scl_fall = ~scl_s & r.scl_q;
      start_seen = scl_s & r.scl_q & r.sda_q & ~sda_s;
      stop_seen = scl_s & r.scl_q & ~r.sda_q & sda_s;

      if (req) begin
         next_r.ack = 1'b1;
         case (adr_i)
            `ISL_OFS_STATUS: begin
               next_r.rd = r.stat;
               if (wr) begin
                  next_r.stat[`ISL_B_TXD] = dat_i[`ISL_B_TXD];
                  next_r.stat[`ISL_B_ACK_TO_SEND] = dat_i[`ISL_B_ACK_TO_SEND];
                  next_r.stat[`ISL_B_WAKE] = dat_i[`ISL_B_WAKE];
               end
            end
            `ISL_OFS_DATA: begin
               next_r.rd = r.data;
               if (wr) begin
                  next_r.data = dat_i[7:0];
               end
               service = (we_i & tx) | (~we_i & ~tx);
            end
            `ISL_OFS_ADDR: begin
               next_r.rd = r.own;
               if (wr) begin
                  next_r.own = dat_i[7:0];
               end
            end
            `ISL_OFS_CTRL: begin
               next_r.rd = {5'h00, r.deb, r.en};
               if (wr) begin
                  next_r.en = dat_i[`ISL_C_EN];
                  next_r.deb = dat_i[`ISL_C_DEB_HI:`ISL_C_DEB_LO];
               end
            end
            default: begin
               next_r.rd = 8'h00;
            end
         endcase
      end

      // Enable rising restores the flags, the ack received flag among them, but leaves the direction, ack-to-send and wake bits alone.
      if (next_r.en & ~r.en) begin
         next_r.stat[`ISL_B_DONE] = 1'b1;
         next_r.stat[`ISL_B_MATCH] = 1'b0;
         next_r.stat[`ISL_B_BUSY] = 1'b0;
         next_r.stat[`ISL_B_RREQ] = 1'b0;
         next_r.stat[`ISL_B_ACK_RECEIVED_FLAG] = 1'b1;
      end

      if (~r.en) begin
         next_r.st = D_IDLE;
         next_r.scl_oe = 1'b0;
         next_r.sda_oe = 1'b0;
      end else if (start_seen) begin
         // A start restarts the frame from any state, including a repeated start.
         next_r.st = D_ADDR;
         next_r.cnt = 4'h0;
         next_r.stat[`ISL_B_BUSY] = 1'b1;
         next_r.stat[`ISL_B_MATCH] = 1'b0;
         next_r.scl_oe = 1'b0;
         next_r.sda_oe = 1'b0;
      end else if (stop_seen) begin
         next_r.st = D_IDLE;
         next_r.stat[`ISL_B_BUSY] = 1'b0;
         next_r.scl_oe = 1'b0;
         next_r.sda_oe = 1'b0;
      end else begin
         case (r.st)
            D_IDLE: begin
               next_r.scl_oe = 1'b0;
               next_r.sda_oe = 1'b0;
            end
            D_ADDR: begin
               if (scl_rise) begin
                  next_r.sh_addr = {r.sh_addr[6:0], sda_s};
                  next_r.cnt = r.cnt + 4'h1;
               end
               if (scl_fall && r.cnt == `ISL_BYTE_BITS) begin
                  if (r.sh_addr[`ISL_ADDR_HI:`ISL_ADDR_LO] == r.own[`ISL_ADDR_HI:`ISL_ADDR_LO]) begin
                     next_r.stat[`ISL_B_MATCH] = 1'b1;
                     next_r.irq = 1'b1;
                     next_r.stat[`ISL_B_RREQ] = r.sh_addr[0];
                     next_r.sda_oe = 1'b1;
                     next_r.st = D_AACK;
                  end else begin
                     // Not addressed: stay off the bus until the next start.
                     next_r.st = D_IDLE;
                  end
               end
            end
            D_AACK: begin
               if (scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  next_r.scl_oe = 1'b1;
                  next_r.st = D_HOLD;
               end
            end
            D_HOLD: begin
               next_r.scl_oe = 1'b1;
               if (service) begin
                  // The first bit goes out while SCL is still held, one cycle before release.
                  next_r.sda_oe = tx & ~next_r.data[`ISL_MSB];
                  next_r.st = D_SETUP;
               end
            end
            D_SETUP: begin
               next_r.scl_oe = 1'b0;
               next_r.cnt = 4'h0;
               next_r.stat[`ISL_B_DONE] = 1'b0;
               next_r.stat[`ISL_B_MATCH] = 1'b0;
               next_r.st = D_DATA;
            end
            D_DATA: begin
               if (scl_rise) begin
                  next_r.data = {r.data[6:0], sda_s};
                  next_r.cnt = r.cnt + 4'h1;
               end
               if (scl_fall) begin
                  if (r.cnt == `ISL_BYTE_BITS) begin
                     next_r.stat[`ISL_B_DONE] = 1'b1;
                     next_r.irq = 1'b1;
                     next_r.sda_oe = ~tx & ~r.stat[`ISL_B_ACK_TO_SEND];
                     next_r.st = D_DACK;
                  end else begin
                     next_r.sda_oe = tx & ~r.data[`ISL_MSB];
                  end
               end
            end
            D_DACK: begin
               if (scl_rise && tx) begin
                  next_r.stat[`ISL_B_ACK_RECEIVED_FLAG] = sda_s;
               end
               if (scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  if (tx && r.stat[`ISL_B_ACK_RECEIVED_FLAG]) begin
                     next_r.st = D_IDLE;
                  end else begin
                     next_r.scl_oe = 1'b1;
                     next_r.st = D_HOLD;
                  end
               end
            end
            default: begin
               next_r.st = D_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.stat <= `ISL_STATUS_RST;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================
   // Outputs.
   assign dat_o = {24'h000000, r.rd};
   assign ack_o = r.ack;
   assign irq_o = r.irq;
   assign bus.scl_s_oe = r.scl_oe;
   assign bus.sda_s_oe = r.sda_oe;
endmodule : isl_slave

`default_nettype wire

// ### rtl/isl_sync.sv
// Two-flop synchroniser with an optional glitch filter of 2 or 4 clocks.
// Assumes d_i is asynchronous to clk_i and idles high.
`timescale 1ns/100ps
`default_nettype none

module isl_sync (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Line and filter setting.
   input wire logic d_i,
   input wire logic [1:0] deb_i,
   output logic q_o
);
   import isl_pkg::*;

   isl_sync_reg_t r;
   isl_sync_reg_t next_r;
   logic [2:0] lim;

   // ==========================================
   // Filter: the output follows only after the input has been stable long enough.
   always_comb begin
      next_r = r;
      next_r.ff1 = d_i;
      next_r.ff2 = r.ff1;
      case (deb_i)
         2'b00: lim = `ISL_DEB_NONE;
         2'b01: lim = `ISL_DEB_TWO;
         default: lim = `ISL_DEB_FOUR;
      endcase
      if (r.ff2 == r.q) begin
         next_r.cnt = 3'h0;
      end else if (r.cnt + 3'h1 >= lim) begin
         next_r.q = r.ff2;
         next_r.cnt = 3'h0;
      end else begin
         next_r.cnt = r.cnt + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '{ff1: 1'b1, ff2: 1'b1, q: 1'b1, cnt: 3'h0};
      end else begin
         r <= next_r;
      end
   end

   assign q_o = r.q;
endmodule : isl_sync

`default_nettype wire

// ### sim/i2c_slave_interface_tb.sv
// Bench: master end and slave end joined by the link, firmware side driven over Wishbone.
// Assumes the rtl files and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "isl_params.svh"

module i2c_slave_interface_tb;
   import isl_pkg::*;
   localparam logic [6:0] own = 7'h2a;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, cv = 1'b0, mack = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, rd;
   logic wack, irq, rdy, nack, done;
   logic [7:0] md = 8'h00, mrd;
   isl_cmd_t cmd = CMD_START;
   logic [16:0] lfsr = 17'h11a1e;
   logic [7:0] exq[$];
   int miscompares = 0, check_count = 0, nirq = 0;

   // ==========================================
   // Structure.
   isl_if isl_if_i ();
   isl_slave isl_slave_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(4'h1), .dat_i(wd), .dat_o(rd), .ack_o(wack), .irq_o(irq), .bus(isl_if_i.slave));
   // The slave filters SCL but not SDA, so its view of an SCL fall lags by up to six clocks.
   // The half period must keep the master's mid-low SDA change behind that lag, or a false start or stop is seen.
   isl_master #(.HALF(16)) isl_master_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cv), .cmd_i(cmd),
      .addr_i(md[7:1]), .rw_i(md[0]), .wdata_i(md), .ack_i(mack), .cmd_ready_o(rdy), .rdata_o(mrd),
      .nack_o(nack), .done_o(done), .bus(isl_if_i.master));
   isl_asserts isl_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .scl_m_oe(isl_if_i.scl_m_oe),
      .sda_m_oe(isl_if_i.sda_m_oe), .scl_s_oe(isl_if_i.scl_s_oe), .sda_s_oe(isl_if_i.sda_s_oe),
      .scl(isl_if_i.scl), .sda(isl_if_i.sda));

   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) if (irq === 1'b1) nirq <= nirq + 1;

   // ==========================================
   // Tasks.
   function automatic logic [7:0] nxt();
      lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
      return lfsr[7:0];
   endfunction : nxt
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %0t got %h expected %h", $time, s, e);
      end
   endtask : chk
   // One wait for all handshakes, so every wait is bounded in the same way.
   task automatic wt(input int w, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (((w == 0) ? wack : (w == 1) ? done : isl_if_i.scl_s_oe) !== 1'b1 && n < lim);
      if (n >= lim) begin
         miscompares++;
         report_and_stop();
      end
   endtask : wt
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= {24'h0, d};
      wt(0, 50);
      r = rd[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic rs(output logic [7:0] r);
      wb(1'b0, `ISL_OFS_STATUS, 8'h00, r);
   endtask : rs
   task automatic mc(input isl_cmd_t c, input logic [7:0] d, input logic a);
      @(posedge clk_i);
      cv <= 1'b1;
      cmd <= c;
      md <= d;
      mack <= a;
      @(posedge clk_i);
      cv <= 1'b0;
      wt(1, 30000);
   endtask : mc
   // Firmware service runs beside the command, because the slave stretches SCL inside it.
   task automatic step(input isl_cmd_t c, input logic [7:0] d, input logic a, input logic s, input logic w,
                       input logic [7:0] fd, output logic [7:0] r);
      fork
         mc(c, d, a);
         if (s) begin
            wt(2, 30000);
            wb(w, `ISL_OFS_DATA, fd, r);
         end
      join
   endtask : step

   // ==========================================
   // Main sequence.
   initial begin
      logic [7:0] r, b;
      int k, d0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rs(r);
      chk(r, 8'h81);
      wb(1'b1, `ISL_OFS_STATUS, 8'hff, r);
      rs(r);
      chk(r, 8'h9b);
      wb(1'b1, 4'h2, 8'hff, r);
      wb(1'b0, 4'h2, 8'h00, r);
      chk(r, 8'h00);
      wb(1'b1, `ISL_OFS_ADDR, {own, 1'b1}, r);
      wb(1'b0, `ISL_OFS_ADDR, 8'h00, r);
      chk(r, {own, 1'b1});
      $display("test registers over");
      for (k = 0; k < 3; k++) begin
         wb(1'b1, `ISL_OFS_STATUS, 8'h00, r);
         wb(1'b1, `ISL_OFS_CTRL, {5'h0, k[1:0], 1'b1}, r);
         d0 = nirq;
         step(CMD_START, {own, 1'b0}, 1'b0, 1'b0, 1'b0, 8'h00, r);
         chk(nack, 1'b0);
         rs(r);
         chk(r & 8'h64, 8'h60);
         chk(nirq - d0, 1);
         b = nxt();
         exq.push_back(b);
         step(CMD_WRITE, b, 1'b0, 1'b1, 1'b0, 8'h00, r);
         chk(nack, 1'b0);
         rs(r);
         chk(r & 8'h80, 8'h80);
         chk(nirq - d0, 2);
         wb(1'b1, `ISL_OFS_STATUS, 8'h08, r);
         b = nxt();
         step(CMD_WRITE, b, 1'b0, 1'b1, 1'b0, 8'h00, r);
         chk(r, exq.pop_front());
         chk(nack, 1'b1);
         exq.push_back(b);
         step(CMD_STOP, 8'h00, 1'b0, 1'b1, 1'b0, 8'h00, r);
         chk(r, exq.pop_front());
         rs(r);
         chk(r & 8'h20, 8'h00);
         step(CMD_START, {own, 1'b1}, 1'b0, 1'b0, 1'b0, 8'h00, r);
         rs(r);
         chk(r & 8'h64, 8'h64);
         wb(1'b1, `ISL_OFS_STATUS, 8'h10, r);
         b = nxt();
         exq.push_back(b);
         step(CMD_READ, 8'h00, 1'b0, 1'b1, 1'b1, b, r);
         chk(mrd, exq.pop_front());
         rs(r);
         chk(r & 8'h01, 8'h00);
         b = nxt();
         exq.push_back(b);
         step(CMD_READ, 8'h00, 1'b1, 1'b1, 1'b1, b, r);
         chk(mrd, exq.pop_front());
         rs(r);
         chk(r & 8'h01, 8'h01);
         step(CMD_STOP, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00, r);
         step(CMD_START, {own ^ 7'h01, 1'b0}, 1'b0, 1'b0, 1'b0, 8'h00, r);
         chk(nack, 1'b1);
         rs(r);
         chk(r & 8'h40, 8'h00);
         step(CMD_STOP, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00, r);
         $display("test transfers with filter %0d over", k);
      end
      wb(1'b1, `ISL_OFS_STATUS, 8'h18, r);
      wb(1'b1, `ISL_OFS_CTRL, 8'h00, r);
      wb(1'b1, `ISL_OFS_CTRL, 8'h01, r);
      rs(r);
      chk(r, 8'h99);
      $display("test enable over");
      report_and_stop();
   end
endmodule : i2c_slave_interface_tb

`default_nettype wire

// ### sim/isl_asserts.sv
// Concurrent checks on the open-drain wires between the master end and the slave end.
// Assumes it is instantiated beside the interface and fed its signals directly.
`timescale 1ns/100ps
`default_nettype none

module isl_asserts (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Link wires.
   input wire logic scl_m_oe,
   input wire logic sda_m_oe,
   input wire logic scl_s_oe,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda
);
   // ==========================================
   // Helper logic.
   // Rises of SCL since the last start; it saturates at 15, so 15 also means no start seen yet.
   logic scl_q;
   logic sda_q;
   logic [3:0] rises;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rises <= 4'hf;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (sda_q && !sda && scl_q && scl) begin
            rises <= 4'h0;
         end else if (scl && !scl_q && rises != 4'hf) begin
            rises <= rises + 4'h1;
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ==========================================
   // Properties.
   sequence s_start;
      sda_q && !sda && scl_q && scl;
   endsequence
   sequence s_stop;
      !sda_q && sda && scl_q && scl;
   endsequence

   property p_addr_quiet;
      rises < 4'h8 |-> !sda_s_oe && !scl_s_oe;
   endproperty
   property p_sda_moves_low;
      $changed(sda_s_oe) |-> !scl;
   endproperty
   property p_ack_through_ninth;
      (rises == 4'h8 && sda_s_oe && !scl) ##1 scl |-> sda_s_oe [*3];
   endproperty
   property p_stretch_low;
      $rose(scl_s_oe) |-> !$past(scl);
   endproperty
   property p_release_order;
      $fell(scl_s_oe) |-> $stable(sda_s_oe);
   endproperty
   property p_stop_frees;
      s_stop |-> ##[0:8] (!sda_s_oe && !scl_s_oe);
   endproperty
   property p_high_min;
      $rose(scl) |-> scl [*4];
   endproperty
   property p_master_sda;
      $changed(sda_m_oe) && scl && scl_q && !sda_s_oe |-> (s_start or s_stop);
   endproperty

   a_addr_quiet: assert property (p_addr_quiet) else $error("slave drove the link during the address");
   a_sda_moves_low: assert property (p_sda_moves_low) else $error("slave moved SDA while SCL high");
   a_ack_through_ninth: assert property (p_ack_through_ninth) else $error("address ack dropped early");
   a_stretch_low: assert property (p_stretch_low) else $error("slave pulled SCL while it was high");
   a_release_order: assert property (p_release_order) else $error("SDA moved as SCL was freed");
   a_stop_frees: assert property (p_stop_frees) else $error("lines not freed after stop");
   a_high_min: assert property (p_high_min) else $error("SCL high phase too short");
   a_master_sda: assert property (p_master_sda) else $error("master moved SDA in SCL high");
endmodule : isl_asserts

`default_nettype wire
